// ===== include/tpsi_defs.vh
`ifndef TPSI_DEFS_VH
`define TPSI_DEFS_VH

// Register byte offsets
`define TPSI_OFF_CTRL      8'h00
`define TPSI_OFF_PCFG      8'h04
`define TPSI_OFF_TXD       8'h08
`define TPSI_OFF_RXD       8'h0c
`define TPSI_OFF_STAT      8'h10
`define TPSI_OFF_CRDIV     8'h14

// Global control fields
`define TPSI_CTRL_MODE     0
`define TPSI_CTRL_HSPEED   1

// Port configuration fields
`define TPSI_PCFG_TXSMP    0
`define TPSI_PCFG_RXSMP    1
`define TPSI_PCFG_TWOCLK   2
`define TPSI_PCFG_TYPE_LO  3
`define TPSI_PCFG_TYPE_HI  4
`define TPSI_PCFG_CTS      5
`define TPSI_PCFG_CDEN     6
`define TPSI_PCFG_CD       7
`define TPSI_PCFG_TSIG     8

// Status fields
`define TPSI_STAT_TXALN    0
`define TPSI_STAT_RXALN    1
`define TPSI_STAT_RXVAL    2
`define TPSI_STAT_RXOVR    3
`define TPSI_STAT_TXRDY    4
`define TPSI_STAT_RTS      5
`define TPSI_STAT_MFSEEN   6

// Interface types
`define TPSI_TYPE_SERIAL   2'h0
`define TPSI_TYPE_E1       2'h1
`define TPSI_TYPE_T1       2'h2

// Reset values and constants
`define TPSI_CTRL_RST      2'h0
`define TPSI_PCFG_RST      9'h000
`define TPSI_CRDIV_RST     16'h0003
`define TPSI_IDLE_BYTE     8'hff
`define TPSI_LAST_BIT      3'h7
`define TPSI_FIRST_BIT     3'h1

// Synchronised input positions
`define TPSI_IN_TCLK       0
`define TPSI_IN_TFS        1
`define TPSI_IN_MF         2
`define TPSI_IN_RXD        3
`define TPSI_IN_RFS        4
`define TPSI_IN_RTS        5
`define TPSI_IN_RCLK       6
`define TPSI_IN_NUM        7

`endif

// ===== hdl/tpsi_sync.v
`timescale 1ns/1ps
`default_nettype none

module tpsi_sync #(
  parameter W = 1
) (
  input  wire         mclk,
  input  wire         rst,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;

  // A change counts once the second and third stages agree
  always @(posedge mclk) begin
    if (rst) begin
      s1 <= {W{1'b0}};
      s2 <= {W{1'b0}};
      s3 <= {W{1'b0}};
      q  <= {W{1'b0}};
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q  <= (s2 & s3) | (q & (s2 | s3));
    end
  end

endmodule // tpsi_sync

`default_nettype wire

// ===== hdl/tpsi_fifo2.v
`timescale 1ns/1ps
`default_nettype none

module tpsi_fifo2 #(
  parameter W  = 8,
  parameter AW = 1
) (
  input  wire         mclk,
  input  wire         rst,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);

  localparam [AW:0] DEPTH = {1'b1, {AW{1'b0}}};
  localparam [AW:0] ONE   = {{AW{1'b0}}, 1'b1};

  reg  [W-1:0]  mem [0:DEPTH-1];
  reg  [AW:0]   cnt;
  reg  [AW-1:0] wp;
  reg  [AW-1:0] rp;
  wire          push;
  wire          pop;

  assign in_ready  = (cnt != DEPTH);
  assign out_valid = (cnt != {(AW+1){1'b0}});
  assign out_data  = mem[rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge mclk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      cnt <= {(AW+1){1'b0}};
      wp  <= {AW{1'b0}};
      rp  <= {AW{1'b0}};
    end else begin
      if (push) begin
        wp <= wp + ONE[AW-1:0];
      end
      if (pop) begin
        rp <= rp + ONE[AW-1:0];
      end
      case ({push, pop})
        2'b10:   cnt <= cnt + ONE;
        2'b01:   cnt <= cnt - ONE;
        default: cnt <= cnt;
      endcase
    end
  end

endmodule // tpsi_fifo2

`default_nettype wire

// ===== hdl/tpsi_top.v
`include "tpsi_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module tpsi_top #(
  parameter PORT_INDEX = 1,
  parameter FIFO_AW    = 1
) (
  input  wire        mclk,
  input  wire        rst,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        tx_tdm_clock,
  input  wire        rx_tdm_clock,
  output reg         tx_serial_out,
  input  wire        tx_frame_sync_in,
  output reg         tx_signaling_cts_out,
  input  wire        tx_multiframe_sync_cd_in,
  output reg         tx_multiframe_sync_cd_out,
  output reg         tx_multiframe_sync_cd_oe_n,
  input  wire        rx_serial_in,
  input  wire        rx_frame_sync_in,
  input  wire        rx_signaling_rts,
  output reg         recovered_clock_out
);

  // Address decode shared by reads and writes
  function hit;
    input [7:0] adr;
    input [7:0] off;
    begin
      hit = (adr[7:2] == off[7:2]);
    end
  endfunction

  reg  [1:0]                ctrl;
  reg  [8:0]                pcfg;
  reg  [15:0]               crdiv;
  reg  [15:0]               cr_cnt;
  reg                       tclk_prev;
  reg                       rclk_prev;
  reg                       tx_aligned;
  reg  [2:0]                tx_cnt;
  reg  [7:0]                tx_cur;
  reg                       rx_aligned;
  reg  [2:0]                rx_cnt;
  reg  [7:0]                rx_sh;
  reg  [7:0]                rx_data;
  reg                       rx_valid;
  reg                       rx_ovr;
  reg                       rts_lvl;
  reg                       mf_seen;
  reg                       rx_pend;
  wire [`TPSI_IN_NUM-1:0]   pin_q;
  wire                      fifo_in_ready;
  wire                      fifo_out_valid;
  wire [7:0]                fifo_out_data;
  wire                      fifo_pop;
  wire                      act;
  wire                      tx_sample;
  wire                      rx_sample;
  wire                      two_clocks;
  wire [1:0]                int_type;
  wire                      is_serial;
  wire                      t_rise;
  wire                      t_fall;
  wire                      r_rise;
  wire                      r_fall;
  wire                      tx_upd;
  wire                      tx_smp;
  wire                      rx_edge;
  wire                      rx_fsync;
  wire                      rx_done;
  wire [7:0]                tx_load;
  wire                      req;
  wire                      wr_txd;
  wire                      take;
  wire                      rd_rxd;
  wire                      rd_stat;
  wire [31:0]               stat_word;
  reg  [31:0]               next_dat;

  tpsi_sync #(
    .W (`TPSI_IN_NUM)
  ) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .d    ({rx_tdm_clock, rx_signaling_rts, rx_frame_sync_in, rx_serial_in,
            tx_multiframe_sync_cd_in, tx_frame_sync_in, tx_tdm_clock}),
    .q    (pin_q)
  );

  tpsi_fifo2 #(
    .W  (8),
    .AW (FIFO_AW)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (wr_txd & take),
    .in_ready  (fifo_in_ready),
    .in_data   (wb_dat_i[7:0]),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // Configuration fields
  assign tx_sample  = pcfg[`TPSI_PCFG_TXSMP];
  assign rx_sample  = pcfg[`TPSI_PCFG_RXSMP];
  assign two_clocks = pcfg[`TPSI_PCFG_TWOCLK];
  assign int_type   = pcfg[`TPSI_PCFG_TYPE_HI:`TPSI_PCFG_TYPE_LO];
  assign is_serial  = (int_type != `TPSI_TYPE_E1) && (int_type != `TPSI_TYPE_T1);

  // Pins live only in external mode, and only port one in high speed
  assign act = ctrl[`TPSI_CTRL_MODE] &
               ~(ctrl[`TPSI_CTRL_HSPEED] & (PORT_INDEX != 1));

  // Edge detection of the sampled link clocks
  assign t_rise  = act & pin_q[`TPSI_IN_TCLK] & ~tclk_prev;
  assign t_fall  = act & ~pin_q[`TPSI_IN_TCLK] & tclk_prev;
  assign r_rise  = act & pin_q[`TPSI_IN_RCLK] & ~rclk_prev;
  assign r_fall  = act & ~pin_q[`TPSI_IN_RCLK] & rclk_prev;
  assign tx_upd  = tx_sample ? t_fall : t_rise;
  assign tx_smp  = tx_sample ? t_rise : t_fall;

  // Receive timing and frame sync source per clocking mode
  assign rx_edge  = two_clocks ? (rx_sample ? r_rise : r_fall)
                               : tx_upd;
  assign rx_fsync = two_clocks ? pin_q[`TPSI_IN_RFS]
                               : rx_pend;
  assign rx_done  = rx_edge & rx_aligned & ~rx_fsync &
                    (rx_cnt == `TPSI_LAST_BIT);

  // Transmit byte source: buffered data or idle fill
  assign tx_load  = fifo_out_valid ? fifo_out_data : `TPSI_IDLE_BYTE;
  assign fifo_pop = tx_upd & tx_aligned & (tx_cnt == 3'h0);

  // Bus request decode; a full buffer holds off the acknowledge
  assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_txd  = req & wb_we_i & hit(wb_adr_i, `TPSI_OFF_TXD);
  assign take    = req & (~wr_txd | fifo_in_ready);
  assign rd_rxd  = take & ~wb_we_i & hit(wb_adr_i, `TPSI_OFF_RXD);
  assign rd_stat = take & ~wb_we_i & hit(wb_adr_i, `TPSI_OFF_STAT);

  assign stat_word = {25'h0000000, mf_seen, rts_lvl, fifo_in_ready,
                      rx_ovr, rx_valid, rx_aligned, tx_aligned};

  always @* begin
    next_dat = 32'h00000000;
    if (hit(wb_adr_i, `TPSI_OFF_CTRL)) begin
      next_dat = {30'h00000000, ctrl};
    end else if (hit(wb_adr_i, `TPSI_OFF_PCFG)) begin
      next_dat = {23'h000000, pcfg};
    end else if (hit(wb_adr_i, `TPSI_OFF_RXD)) begin
      next_dat = {24'h000000, rx_data};
    end else if (hit(wb_adr_i, `TPSI_OFF_STAT)) begin
      next_dat = stat_word;
    end else if (hit(wb_adr_i, `TPSI_OFF_CRDIV)) begin
      next_dat = {16'h0000, crdiv};
    end
  end

  // Wishbone slave: one-cycle answer except TXD writes to a full buffer, unmapped reads give zero
  always @(posedge mclk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl     <= `TPSI_CTRL_RST;
      pcfg     <= `TPSI_PCFG_RST;
      crdiv    <= `TPSI_CRDIV_RST;
    end else begin
      wb_ack_o <= take;
      if (take & ~wb_we_i) begin
        wb_dat_o <= next_dat;
      end
      if (take & wb_we_i) begin
        if (hit(wb_adr_i, `TPSI_OFF_CTRL) & wb_sel_i[0]) begin
          ctrl <= wb_dat_i[1:0];
        end
        if (hit(wb_adr_i, `TPSI_OFF_PCFG)) begin
          if (wb_sel_i[0]) begin
            pcfg[7:0] <= wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            pcfg[8] <= wb_dat_i[8];
          end
        end
        if (hit(wb_adr_i, `TPSI_OFF_CRDIV)) begin
          if (wb_sel_i[0]) begin
            crdiv[7:0] <= wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            crdiv[15:8] <= wb_dat_i[15:8];
          end
        end
      end
    end
  end

  // Clock edge history
  always @(posedge mclk) begin
    if (rst) begin
      tclk_prev <= 1'b0;
      rclk_prev <= 1'b0;
    end else begin
      tclk_prev <= pin_q[`TPSI_IN_TCLK];
      rclk_prev <= pin_q[`TPSI_IN_RCLK];
    end
  end

  // Recovery machine: programmable divider toggling the output
  always @(posedge mclk) begin
    if (rst) begin
      cr_cnt              <= 16'h0000;
      recovered_clock_out <= 1'b0;
    end else if (!act) begin
      cr_cnt              <= 16'h0000;
      recovered_clock_out <= 1'b0;
    end else if (cr_cnt >= crdiv) begin
      cr_cnt              <= 16'h0000;
      recovered_clock_out <= ~recovered_clock_out;
    end else begin
      cr_cnt <= cr_cnt + 16'h0001;
    end
  end

  // Transmit framing and serialiser
  always @(posedge mclk) begin
    if (rst) begin
      tx_aligned    <= 1'b0;
      tx_cnt        <= 3'h0;
      tx_cur        <= `TPSI_IDLE_BYTE;
      tx_serial_out <= 1'b0;
    end else if (!act) begin
      tx_aligned    <= 1'b0;
      tx_cnt        <= 3'h0;
      tx_serial_out <= 1'b0;
    end else begin
      if (tx_smp & pin_q[`TPSI_IN_TFS]) begin
        // Bit on the line now is the first of a frame
        tx_aligned <= 1'b1;
        tx_cnt     <= `TPSI_FIRST_BIT;
        if (!tx_aligned) begin
          tx_cur <= `TPSI_IDLE_BYTE;
        end
      end else if (tx_upd) begin
        if (!tx_aligned) begin
          tx_serial_out <= 1'b1;
        end else if (tx_cnt == 3'h0) begin
          tx_cur        <= tx_load;
          tx_serial_out <= tx_load[7];
          tx_cnt        <= tx_cnt + 3'h1;
        end else begin
          tx_serial_out <= tx_cur[~tx_cnt];
          tx_cnt        <= tx_cnt + 3'h1;
        end
      end
    end
  end

  // Signaling, clear-to-send and carrier detect pins
  always @(posedge mclk) begin
    if (rst) begin
      tx_signaling_cts_out       <= 1'b0;
      tx_multiframe_sync_cd_out  <= 1'b0;
      tx_multiframe_sync_cd_oe_n <= 1'b1;
      mf_seen                    <= 1'b0;
    end else begin
      if (!act) begin
        tx_signaling_cts_out <= 1'b0;
      end else if (tx_upd) begin
        tx_signaling_cts_out <= is_serial ? pcfg[`TPSI_PCFG_CTS]
                                          : pcfg[`TPSI_PCFG_TSIG];
      end
      tx_multiframe_sync_cd_oe_n <= ~(act & is_serial & pcfg[`TPSI_PCFG_CDEN]);
      tx_multiframe_sync_cd_out  <= act & pcfg[`TPSI_PCFG_CD];
      mf_seen <= (tx_smp & ~is_serial & pin_q[`TPSI_IN_MF]) |
                 (mf_seen & ~rd_stat);
    end
  end

  // Receive framing and deserialiser
  always @(posedge mclk) begin
    if (rst) begin
      rx_aligned <= 1'b0;
      rx_cnt     <= 3'h0;
      rx_sh      <= 8'h00;
      rx_data    <= 8'h00;
      rts_lvl    <= 1'b0;
      rx_pend    <= 1'b0;
    end else if (!act) begin
      rx_aligned <= 1'b0;
      rx_cnt     <= 3'h0;
      rx_pend    <= 1'b0;
    end else if (rx_edge) begin
      rts_lvl <= pin_q[`TPSI_IN_RTS];
      rx_sh   <= {rx_sh[6:0], pin_q[`TPSI_IN_RXD]};
      rx_pend <= 1'b0;
      if (rx_fsync) begin
        rx_aligned <= 1'b1;
        rx_cnt     <= `TPSI_FIRST_BIT;
      end else if (rx_aligned) begin
        rx_cnt <= rx_cnt + 3'h1;
        if (rx_done) begin
          rx_data <= {rx_sh[6:0], pin_q[`TPSI_IN_RXD]};
        end
      end
    end else if (tx_smp & ~two_clocks & pin_q[`TPSI_IN_TFS]) begin
      // Sync seen on the sample edge makes the next receive bit the first
      rx_pend <= 1'b1;
    end
  end

  // Receive flags: a new byte wins over a read in the same cycle
  always @(posedge mclk) begin
    if (rst) begin
      rx_valid <= 1'b0;
      rx_ovr   <= 1'b0;
    end else begin
      rx_valid <= rx_done | (rx_valid & ~rd_rxd);
      rx_ovr   <= (rx_done & rx_valid & ~rd_rxd) | (rx_ovr & ~rd_rxd);
    end
  end

endmodule // tpsi_top

`default_nettype wire

// ===== tb/tpsi_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpsi_defs.vh"

module tpsi_top_chk (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        tx_tdm_clock,
  input wire logic        tx_serial_out,
  input wire logic        tx_signaling_cts_out,
  input wire logic        tx_multiframe_sync_cd_out,
  input wire logic        tx_multiframe_sync_cd_oe_n,
  input wire logic        recovered_clock_out
);
  logic       mode;
  logic       cden;
  logic       txsmp;
  logic       t1;
  logic       t2;
  logic [1:0] ityp;
  logic [3:0] on_cnt;
  logic [4:0] age;
  wire        wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  wire        ok = mode && cden && (ityp == 2'h0 || ityp == 2'h3);

  // Shadow of control fields, taken at the bus take edge
  always @(posedge mclk) begin
    if (rst) begin
      mode   <= 1'h0;
      cden   <= 1'h0;
      txsmp  <= 1'h0;
      ityp   <= 2'h0;
      on_cnt <= 4'h0;
      age    <= 5'h1f;
    end else begin
      if (wr && wb_adr_i == `TPSI_OFF_CTRL)
        mode <= wb_dat_i[`TPSI_CTRL_MODE];
      if (wr && wb_adr_i == `TPSI_OFF_PCFG) begin
        txsmp <= wb_dat_i[`TPSI_PCFG_TXSMP];
        cden  <= wb_dat_i[`TPSI_PCFG_CDEN];
        ityp  <= wb_dat_i[`TPSI_PCFG_TYPE_HI:`TPSI_PCFG_TYPE_LO];
      end
      on_cnt <= !mode ? 4'h0 : (on_cnt == 4'hf ? on_cnt : on_cnt + 4'h1);
      age    <= (t1 != t2 && t1 != txsmp) ? 5'h0 : (age == 5'h1f ? age : age + 5'h1);
    end
    t1 <= tx_tdm_clock;
    t2 <= t1;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_reset_quiet: assert property (
    $past(rst) |-> !wb_ack_o && !tx_serial_out && tx_multiframe_sync_cd_oe_n && !recovered_clock_out)
    else $error("outputs not quiet after reset");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_time: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o && !(wb_we_i && wb_adr_i == `TPSI_OFF_TXD) |=> wb_ack_o)
    else $error("ack late");
  chk_unmapped_zero: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i[7:2] > 6'h5 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_pins_off: assert property (
    !mode && !$past(mode) |-> !tx_serial_out && !tx_signaling_cts_out && !tx_multiframe_sync_cd_out
      && tx_multiframe_sync_cd_oe_n && !recovered_clock_out)
    else $error("pins active while off");
  chk_tx_edge: assert property (
    on_cnt == 4'hf && $changed(tx_serial_out) |-> age >= 5'h2 && age <= 5'h8)
    else $error("serial out changed away from update edge");
  chk_rclk_rate: assert property (disable iff (rst || !mode)
    on_cnt == 4'hf && $changed(recovered_clock_out) |=> $stable(recovered_clock_out) [*3]
      ##1 $changed(recovered_clock_out))
    else $error("recovered clock period wrong");
  chk_cd_enable: assert property (
    ok == $past(ok) |-> tx_multiframe_sync_cd_oe_n == !ok)
    else $error("carrier detect enable wrong");
endmodule // tpsi_top_chk

bind tpsi_top tpsi_top_chk CHK (.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .tx_tdm_clock(tx_tdm_clock), .tx_serial_out(tx_serial_out),
  .tx_signaling_cts_out(tx_signaling_cts_out), .tx_multiframe_sync_cd_out(tx_multiframe_sync_cd_out),
  .tx_multiframe_sync_cd_oe_n(tx_multiframe_sync_cd_oe_n), .recovered_clock_out(recovered_clock_out));

`default_nettype wire

// ===== tb/tpsi_framer_model.sv
`timescale 1ns/1ps
`default_nettype none

module tpsi_framer_model (
  input wire logic edge_sel,
  input wire logic mf_en,
  input wire logic tx_serial_out,
  output var logic tx_tdm_clock,
  output var logic tx_frame_sync_in,
  output var logic tx_multiframe_sync_cd_in,
  output var logic rx_serial_in
);
  // Outside frames the clock stands, sync is pulled low, rx data pulled high
  initial begin
    tx_tdm_clock = 1'h0;
    tx_frame_sync_in = 1'h0;
    tx_multiframe_sync_cd_in = 1'h0;
    rx_serial_in = 1'h1;
  end

  // One 32-bit frame, rx sent MSB first, tx captured at sample edges
  task automatic run_frame(input logic [31:0] rxw, output logic [31:0] txw);
    int i;
    begin
      txw = 32'h0;
      #1;
      tx_tdm_clock = edge_sel;
      #61.5;
      for (i = 0; i <= 32; i++) begin
        tx_tdm_clock = !edge_sel;
        tx_frame_sync_in = (i == 0);
        tx_multiframe_sync_cd_in = mf_en && (i == 0);
        #62.5;
        tx_tdm_clock = edge_sel;
        if (i < 32) begin
          txw[31-i] = tx_serial_out;
          rx_serial_in = rxw[31-i];
        end else
          rx_serial_in = 1'h1;
        #62.5;
      end
      tx_tdm_clock = edge_sel;
    end
  endtask
endmodule // tpsi_framer_model

`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpsi_defs.vh"
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin miscompares++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end

module tb_top;
  logic        mclk, rst, wb_cyc, wb_stb, wb_we, edge_sel, rts, rclk, mf_en, mf;
  logic [3:0]  wb_sel;
  logic [7:0]  wb_adr;
  logic [31:0] wb_wdat, wb_dat_o, q, txw;
  logic        wb_ack_o, tclk, fsync, rxd, txd, cts, cd_out, cd_oe_n, rco;
  int          miscompares, check_count, cycles;

  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  tpsi_top DUT (.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .tx_tdm_clock(tclk), .rx_tdm_clock(rclk), .tx_serial_out(txd), .tx_frame_sync_in(fsync),
    .tx_signaling_cts_out(cts), .tx_multiframe_sync_cd_in(mf), .tx_multiframe_sync_cd_out(cd_out),
    .tx_multiframe_sync_cd_oe_n(cd_oe_n), .rx_serial_in(rxd), .rx_frame_sync_in(1'h0),
    .rx_signaling_rts(rts), .recovered_clock_out(rco));

  tpsi_framer_model FR (.edge_sel(edge_sel), .mf_en(mf_en), .tx_serial_out(txd), .tx_tdm_clock(tclk),
    .tx_frame_sync_in(fsync), .tx_multiframe_sync_cd_in(mf), .rx_serial_in(rxd));

  task finish_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= we;
    wb_sel <= 4'hf;
    wb_adr <= a;
    wb_wdat <= d;
    @(posedge mclk);
    while (wb_ack_o !== 1'h1) @(posedge mclk);
    q = wb_dat_o;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'h1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    wb(1'h0, a, 32'h0);
  endtask

  task t_reset;
    rd(`TPSI_OFF_CTRL); `CHK("ctrl", 32'h0, q)
    rd(`TPSI_OFF_PCFG); `CHK("pcfg", 32'h0, q)
    rd(`TPSI_OFF_CRDIV); `CHK("crdiv", 32'h3, q)
    rd(`TPSI_OFF_STAT); `CHK("stat", 32'h10, q)
    wr(8'h1c, 32'hffffffff);
    rd(8'h1c); `CHK("unmapped", 32'h0, q)
    $display("t_reset done");
  endtask

  task t_off;
    FR.run_frame(32'h5a5a5a5a, txw); `CHK("tx off", 32'h0, txw)
    rd(`TPSI_OFF_STAT); `CHK("stat off", 32'h10, q)
    $display("t_off done");
  endtask

  task t_one;
    edge_sel <= 1'h0;
    wr(`TPSI_OFF_CTRL, 32'h1);
    wr(`TPSI_OFF_TXD, 32'ha5);
    wr(`TPSI_OFF_TXD, 32'h3c);
    rd(`TPSI_OFF_STAT); `CHK("stat full", 32'h0, q)
    FR.run_frame(32'h960ff05a, txw); `CHK("tx rise", 32'hffa53cff, txw)
    rd(`TPSI_OFF_STAT); `CHK("stat rx", 32'h1f, q)
    rd(`TPSI_OFF_RXD); `CHK("rxd rise", 32'h5a, q)
    rd(`TPSI_OFF_STAT); `CHK("stat clr", 32'h13, q)
    $display("t_one done");
  endtask

  task t_fall;
    wr(`TPSI_OFF_CTRL, 32'h0);
    wr(`TPSI_OFF_PCFG, 32'h1);
    edge_sel <= 1'h1;
    wr(`TPSI_OFF_CTRL, 32'h3);
    wr(`TPSI_OFF_TXD, 32'hc3);
    FR.run_frame(32'h000000e7, txw); `CHK("tx fall", 32'hffc3ffff, txw)
    rd(`TPSI_OFF_RXD); `CHK("rxd fall", 32'he7, q)
    $display("t_fall done");
  endtask

  task t_two;
    wr(`TPSI_OFF_CTRL, 32'h0);
    wr(`TPSI_OFF_PCFG, 32'h4);
    edge_sel <= 1'h0;
    rts <= 1'h1;
    wr(`TPSI_OFF_CTRL, 32'h1);
    FR.run_frame(32'h12345678, txw); `CHK("tx two", 32'hffffffff, txw)
    rd(`TPSI_OFF_STAT); `CHK("stat no rclk", 32'h11, q)
    rclk <= 1'h1;
    repeat (8) @(posedge mclk);
    rclk <= 1'h0;
    repeat (8) @(posedge mclk);
    rd(`TPSI_OFF_STAT); `CHK("stat two", 32'h31, q)
    $display("t_two done");
  endtask

  task t_types;
    int t;
    for (t = 0; t < 4; t++) begin
      wr(`TPSI_OFF_PCFG, 32'he0 | (t << 3));
      repeat (2) @(posedge mclk);
      `CHK("cd oe_n", (t == 1 || t == 2) ? 1'h1 : 1'h0, cd_oe_n)
      `CHK("cd out", 1'h1, cd_out)
    end
    mf_en <= 1'h1;
    FR.run_frame(32'h0, txw); `CHK("cts serial", 1'h1, cts)
    rd(`TPSI_OFF_STAT); `CHK("mf serial", 32'h3f, q)
    wr(`TPSI_OFF_PCFG, 32'h28);
    FR.run_frame(32'h0, txw); `CHK("cts e1", 1'h0, cts)
    rd(`TPSI_OFF_STAT); `CHK("mf e1", 32'h7f, q)
    $display("t_types done");
  endtask

  initial begin
    rst = 1'h1;
    wb_cyc = 1'h0;
    wb_stb = 1'h0;
    wb_we = 1'h0;
    wb_adr = 8'h0;
    wb_sel = 4'h0;
    wb_wdat = 32'h0;
    rclk = 1'h0;
    mf_en = 1'h0;
    edge_sel = 1'h0;
    rts = 1'h0;
    repeat (5) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    t_reset;
    t_off;
    t_one;
    t_fall;
    t_two;
    t_types;
    finish_test;
  end
endmodule // tb_top

`default_nettype wire
